// *** src/dimr_defines.svh ***
/*
 Constants of the DDR init and mode register pair: command codes,
 mode field positions, register offsets and timing counts.
 Assumes inclusion by bare name; definitions only.
*/
`ifndef DIMR_DEFINES_SVH
`define DIMR_DEFINES_SVH

// Command codes {csN, rasN, casN, weN}
`define DIMR_CMD_NOP   4'h7
`define DIMR_CMD_LOAD  4'h0
`define DIMR_CMD_PRE   4'h2
`define DIMR_CMD_REF   4'h1
`define DIMR_CMD_RD    4'h5
`define DIMR_CMD_WR    4'h4

// Address bit positions
`define DIMR_BT_BIT    3
`define DIMR_A8_BIT    8
`define DIMR_A10_BIT   10
`define DIMR_BL_MSB    2
`define DIMR_CL_MSB    6
`define DIMR_CL_LSB    4
`define DIMR_EDLL_BIT  0
`define DIMR_EHALF_BIT 1

// Field encodings
`define DIMR_BL2       3'h1
`define DIMR_BL4       3'h2
`define DIMR_BL8       3'h3
`define DIMR_CL2       3'h2
`define DIMR_CL25      3'h6
`define DIMR_CL3       3'h3
`define DIMR_BA_MODE   2'h0
`define DIMR_BA_EXT    2'h1

// Register offsets and fields
`define DIMR_REG_CTRL   8'h00
`define DIMR_REG_MODE   8'h04
`define DIMR_REG_EMODE  8'h08
`define DIMR_REG_ADDR   8'h0C
`define DIMR_REG_WDATA  8'h10
`define DIMR_REG_STATUS 8'h14
`define DIMR_REG_RDATA  8'h18
`define DIMR_MODE_RST   13'h0062
`define DIMR_BANK_LSB   12
`define DIMR_MASK_LSB   16

// Timing
`define DIMR_POWER_US  200
`define DIMR_CLK_MHZ   125
`define DIMR_LOCK      16'h00C8
`define DIMR_GAP       16'h0002
`define DIMR_LOAD_BUSY 16'h0002

`endif

// *** src/dimr_pkg.sv ***
/*
 Types and shared decodes of the DDR init and mode register pair.
 Assumes dimr_defines.svh is on the include path.
*/
`include "dimr_defines.svh"
package dimr_pkg;
   typedef enum logic [3:0] {
      S_OFF, S_PWR, S_NOP, S_PREA1, S_EXT_MODE_REG_LOAD, S_MRS1, S_PREA2,
      S_REF1, S_REF2, S_MRS2, S_READY, S_WRITE, S_READ
   } dimr_state_t;

   // Beats per burst; reserved codes fall back to two
   function automatic logic [3:0] burstBeats(input logic [2:0] code);
      case (code)
         `DIMR_BL4: return 4'h4;
         `DIMR_BL8: return 4'h8;
         default:   return 4'h2;
      endcase
   endfunction

   // Column offset of a beat inside its aligned block
   function automatic logic [2:0] burstOff(input logic [2:0] start,
                                           input logic [2:0] beat,
                                           input logic [3:0] bl,
                                           input logic       il);
      logic [2:0] m;
      m = 3'(bl - 4'h1);
      return (start & ~m) | ((il ? (start ^ beat) : 3'(start + beat)) & m);
   endfunction
endpackage

// *** src/dimr_if.sv ***
/*
 Link between memory controller and DDR device: command pins,
 data, strobes and masks. Resolves each two-way wire from enables.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
interface dimr_if;
   logic        cke;
   logic        csN;
   logic        rasN;
   logic        casN;
   logic        weN;
   logic [1:0]  ba;
   logic [12:0] addr;
   logic [1:0]  dm;
   logic [15:0] dqCtl;
   logic        dqCtlOe;
   logic [15:0] dqDev;
   logic        dqDevOe;
   logic [1:0]  dqsCtl;
   logic        dqsCtlOe;
   logic [1:0]  dqsDev;
   logic        dqsDevOe;
   // Device wins only while it drives; bus keeps controller value else
   wire  [15:0] dq  = dqDevOe ? dqDev : dqCtl;
   wire  [1:0]  dqs = dqsDevOe ? dqsDev : dqsCtl;

   modport ctrl (output cke, csN, rasN, casN, weN, ba, addr, dm,
                 output dqCtl, dqCtlOe, dqsCtl, dqsCtlOe,
                 input dq, dqs, dqDevOe);
   modport dev  (input cke, csN, rasN, casN, weN, ba, addr, dm,
                 input dq, dqs, dqCtlOe,
                 output dqDev, dqDevOe, dqsDev, dqsDevOe);
endinterface

// *** src/dimr_dev.sv ***
/*
 DDR device end: command decode, mode and extended mode registers,
 burst ordering, read latency, masked writes, DLL state.
 Assumes the controller obeys init order and command spacing.
 One data beat per clock; rows are not modelled.
*/
`timescale 1ns/100ps
`include "dimr_defines.svh"
module dimr_dev #(
   parameter int COL_W = 4
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_b,
   // Link
   dimr_if.dev       ddr,
   // Status
   output logic      halfDrive,
   output logic      dllOn,
   output logic      selfRef
);
   if (COL_W < 3 || COL_W > 10) begin : g_chk
      $error("COL_W must lie in 3..10");
   end

   localparam int DEPTH = 4 << COL_W;

   logic [12:0]      modeReg;
   logic [12:0]      extReg;
   logic             ckePrev;
   logic [15:0]      mem [0:DEPTH-1];
   logic             wrAct;
   logic             rdAct;
   logic [2:0]       rdWait;
   logic [3:0]       beat;
   logic [1:0]       burstBa;
   logic [COL_W-1:0] burstCol;
   logic [3:0]       bl;
   logic             il;
   logic [3:0]       cmd;
   logic [2:0]       lat;
   logic [COL_W-1:0] col;

   assign cmd = {ddr.csN, ddr.rasN, ddr.casN, ddr.weN};
   assign bl  = dimr_pkg::burstBeats(modeReg[`DIMR_BL_MSB:0]);
   assign il  = modeReg[`DIMR_BT_BIT];
   // Column of the current beat, wrapped inside its block
   assign col = {burstCol[COL_W-1:3],
                 dimr_pkg::burstOff(burstCol[2:0], beat[2:0], bl, il)};

   // Half clock latency rounds up: one clock domain, no falling edge
   always_comb begin
      case (modeReg[`DIMR_CL_MSB:`DIMR_CL_LSB])
         `DIMR_CL2: lat = 3'h2;
         default:   lat = 3'h3;
      endcase
   end

   // Mode loads; contents held until the next load
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         modeReg <= `DIMR_MODE_RST;
         extReg  <= '0;
      end else if (ddr.cke && cmd == `DIMR_CMD_LOAD) begin
         if (ddr.ba == `DIMR_BA_MODE)
            modeReg <= ddr.addr;
         else if (ddr.ba == `DIMR_BA_EXT)
            extReg <= ddr.addr;
      end
   end

   // Self refresh tracking and DLL state
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ckePrev   <= 1'b0;
         selfRef   <= 1'b0;
         dllOn     <= 1'b0;
         halfDrive <= 1'b0;
      end else begin
         ckePrev <= ddr.cke;
         if (ckePrev && !ddr.cke && cmd == `DIMR_CMD_REF)
            selfRef <= 1'b1;
         else if (!ckePrev && ddr.cke)
            selfRef <= 1'b0;
         dllOn     <= !extReg[`DIMR_EDLL_BIT] && !selfRef;
         halfDrive <= extReg[`DIMR_EHALF_BIT];
      end
   end

   // Burst sequencing and read drive
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wrAct        <= 1'b0;
         rdAct        <= 1'b0;
         rdWait       <= '0;
         beat         <= '0;
         burstBa      <= '0;
         burstCol     <= '0;
         ddr.dqDev    <= '0;
         ddr.dqDevOe  <= 1'b0;
         ddr.dqsDev   <= '0;
         ddr.dqsDevOe <= 1'b0;
      end else begin
         ddr.dqDevOe  <= 1'b0;
         ddr.dqsDevOe <= 1'b0;
         if (ddr.cke && cmd == `DIMR_CMD_WR) begin
            wrAct    <= 1'b1;
            beat     <= '0;
            burstBa  <= ddr.ba;
            burstCol <= ddr.addr[COL_W-1:0];
         end else if (ddr.cke && cmd == `DIMR_CMD_RD) begin
            // Drive one edge early so data stands at command edge plus latency
            rdWait   <= lat - 3'h2;
            rdAct    <= (lat == 3'h2);
            beat     <= '0;
            burstBa  <= ddr.ba;
            burstCol <= ddr.addr[COL_W-1:0];
         end else if (wrAct) begin
            beat <= beat + 4'h1;
            if (beat == bl - 4'h1)
               wrAct <= 1'b0;
         end else if (rdWait != 3'h0) begin
            rdWait <= rdWait - 3'h1;
            rdAct  <= (rdWait == 3'h1);
         end
         // Data edge lands at command edge plus latency
         if (rdAct) begin
            ddr.dqDev    <= mem[{burstBa, col}];
            ddr.dqDevOe  <= 1'b1;
            ddr.dqsDev   <= {2{~beat[0]}};
            ddr.dqsDevOe <= 1'b1;
            beat         <= beat + 4'h1;
            if (beat == bl - 4'h1)
               rdAct <= 1'b0;
         end
      end
   end

   // Masked byte writes, lanes independent; reads never masked
   always_ff @(posedge clk) begin
      if (wrAct) begin
         for (int l = 0; l < 2; l++) begin
            if (!ddr.dm[l])
               mem[{burstBa, col}][l*8 +: 8] <= ddr.dq[l*8 +: 8];
         end
      end
   end
endmodule

// *** src/dimr_ctrl.sv ***
/*
 Memory controller end: APB register slave, power-up and init
 command sequence, mode programming, single write and read bursts.
 Assumes the device shares clk and answers on the dimr_if link.
*/
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/100ps
`include "dimr_defines.svh"
// Overview of operation
// - Masked write beats discarded, reads unaffected
// - Lower mask low byte, upper mask high
// - Clock gate low in power-up; outputs off
// - Wait 200 us before first command
// - NOP, raise clock gate, then precharge all
// - Extended load enables DLL, then DLL reset
// - 200 cycles after DLL reset before read
// - Precharge all, then two auto refreshes
// - Final mode load without DLL reset
// - Mode load: all strobes low, bank0 low
// - Load only idle, clock gate high before
// - Mode load occupies two cycles, no commands
// - Mode fields held until next load
// - Burst length 2, 4, 8 only
// - Burst wraps within aligned column block
// - Address bit 3 picks burst type
// - Sequential beats increment modulo burst length
// - Interleaved offset is start XOR beat
// - Read data after latency 2, 2.5, 3; the device model serves 2.5 at 3
// - DLL off in self refresh, back after
// - 200 cycles after DLL enable before commands
// - Half strength option halves output drive
// - Extended load: bank0 high, bank1 low
module dimr_ctrl #(
   parameter int POWER_CYCLES = `DIMR_POWER_US * `DIMR_CLK_MHZ
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // APB slave
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Link
   dimr_if.ctrl             ddr
);
   if (POWER_CYCLES < 2 || POWER_CYCLES > 65535) begin : g_chk
      $error("POWER_CYCLES must lie in 2..65535");
   end
   dimr_pkg::dimr_state_t state;
   logic [15:0] waitCnt;
   logic [3:0]  beat;
   logic [12:0] mode;
   logic [12:0] emode;
   logic [9:0]  col;
   logic [1:0]  bank;
   logic [1:0]  mask;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic        rdValid;
   logic        initReq;
   logic        wrReq;
   logic        rdReq;
   logic        setup;
   logic        wrDone;
   logic        hit;
   logic        takeInit;
   logic        idleFree;
   logic        takeWr;
   logic        takeRd;
   logic [3:0]  bl;
   logic [31:0] rdMux;

   assign setup    = psel && penable && !pready;
   assign wrDone   = psel && penable && pready && pwrite && !pslverr;
   assign takeInit = (state == dimr_pkg::S_OFF) && initReq;
   assign idleFree = (state == dimr_pkg::S_READY) && (waitCnt == 16'h0000);
   assign takeWr   = idleFree && wrReq;
   assign takeRd   = idleFree && !wrReq && rdReq;
   assign bl       = dimr_pkg::burstBeats(mode[`DIMR_BL_MSB:0]);

   // Address decode and read mux; unmapped reads zero
   always_comb begin
      hit   = 1'b1;
      rdMux = '0;
      case (paddr)
         `DIMR_REG_CTRL:   rdMux = '0;
         `DIMR_REG_MODE:   rdMux = {19'h00000, mode};
         `DIMR_REG_EMODE:  rdMux = {19'h00000, emode};
         `DIMR_REG_ADDR:   rdMux = {14'h0000, mask, 2'h0, bank, 2'h0, col};
         `DIMR_REG_WDATA:  rdMux = {16'h0000, wdata};
         `DIMR_REG_STATUS: rdMux = {28'h0000000, rdValid,
                                    state != dimr_pkg::S_READY,
                                    state == dimr_pkg::S_READY, 1'b0};
         `DIMR_REG_RDATA:  rdMux = {16'h0000, rdata};
         default:          hit   = 1'b0;
      endcase
   end

   // APB answer after one wait cycle
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pready  <= 1'b0;
         prdata  <= '0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         if (setup) begin
            prdata  <= pwrite ? 32'h00000000 : rdMux;
            pslverr <= !hit;
         end
      end
   end

   // Software registers; reserved mode codes are software's burden
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mode  <= `DIMR_MODE_RST;
         emode <= '0;
         col   <= '0;
         bank  <= '0;
         mask  <= '0;
         wdata <= '0;
      end else if (wrDone) begin
         case (paddr)
            `DIMR_REG_MODE:  mode  <= pwdata[12:0];
            `DIMR_REG_EMODE: emode <= pwdata[12:0];
            `DIMR_REG_ADDR: begin
               col  <= pwdata[9:0];
               bank <= pwdata[`DIMR_BANK_LSB +: 2];
               mask <= pwdata[`DIMR_MASK_LSB +: 2];
            end
            `DIMR_REG_WDATA: wdata <= pwdata[15:0];
            default: ;
         endcase
      end
   end

   // Start requests; a new set wins over the taking clear
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         initReq <= 1'b0;
         wrReq   <= 1'b0;
         rdReq   <= 1'b0;
      end else begin
         initReq <= (initReq && !takeInit) ||
                    (wrDone && paddr == `DIMR_REG_CTRL && pwdata[0]);
         wrReq   <= (wrReq && !takeWr) ||
                    (wrDone && paddr == `DIMR_REG_CTRL && pwdata[1]);
         rdReq   <= (rdReq && !takeRd) ||
                    (wrDone && paddr == `DIMR_REG_CTRL && pwdata[2]);
      end
   end

   // Init sequence and bursts; every command followed by a wait
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state        <= dimr_pkg::S_OFF;
         waitCnt      <= '0;
         beat         <= '0;
         rdata        <= '0;
         rdValid      <= 1'b0;
         ddr.cke      <= 1'b0;
         {ddr.csN, ddr.rasN, ddr.casN, ddr.weN} <= `DIMR_CMD_NOP;
         ddr.ba       <= '0;
         ddr.addr     <= '0;
         ddr.dm       <= '0;
         ddr.dqCtl    <= '0;
         ddr.dqCtlOe  <= 1'b0;
         ddr.dqsCtl   <= '0;
         ddr.dqsCtlOe <= 1'b0;
      end else begin
         {ddr.csN, ddr.rasN, ddr.casN, ddr.weN} <= `DIMR_CMD_NOP;
         ddr.dqCtlOe  <= 1'b0;
         ddr.dqsCtlOe <= 1'b0;
         if (waitCnt != 16'h0000)
            waitCnt <= waitCnt - 16'h0001;
         case (state)
            dimr_pkg::S_OFF: begin
               if (takeInit) begin
                  state   <= dimr_pkg::S_PWR;
                  waitCnt <= 16'(POWER_CYCLES - 1);
               end
            end
            dimr_pkg::S_PWR: begin
               if (waitCnt == 16'h0000)
                  state <= dimr_pkg::S_NOP;
            end
            dimr_pkg::S_NOP: begin
               ddr.cke <= 1'b1;
               waitCnt <= `DIMR_GAP;
               state   <= dimr_pkg::S_PREA1;
            end
            dimr_pkg::S_PREA1, dimr_pkg::S_PREA2: begin
               if (waitCnt == 16'h0000) begin
                  {ddr.csN, ddr.rasN, ddr.casN, ddr.weN} <= `DIMR_CMD_PRE;
                  ddr.addr <= '0;
                  ddr.addr[`DIMR_A10_BIT] <= 1'b1;
                  waitCnt  <= `DIMR_GAP;
                  state    <= (state == dimr_pkg::S_PREA1) ?
                              dimr_pkg::S_EXT_MODE_REG_LOAD : dimr_pkg::S_REF1;
               end
            end
            dimr_pkg::S_EXT_MODE_REG_LOAD: begin
               if (waitCnt == 16'h0000) begin
                  {ddr.csN, ddr.rasN, ddr.casN, ddr.weN} <= `DIMR_CMD_LOAD;
                  ddr.ba   <= `DIMR_BA_EXT;
                  ddr.addr <= emode;
                  ddr.addr[`DIMR_EDLL_BIT] <= 1'b0;
                  waitCnt  <= `DIMR_LOCK;
                  state    <= dimr_pkg::S_MRS1;
               end
            end
            dimr_pkg::S_MRS1: begin
               if (waitCnt == 16'h0000) begin
                  {ddr.csN, ddr.rasN, ddr.casN, ddr.weN} <= `DIMR_CMD_LOAD;
                  ddr.ba   <= `DIMR_BA_MODE;
                  ddr.addr <= mode;
                  ddr.addr[`DIMR_A8_BIT] <= 1'b1;
                  waitCnt  <= `DIMR_LOCK;
                  state    <= dimr_pkg::S_PREA2;
               end
            end
            dimr_pkg::S_REF1, dimr_pkg::S_REF2: begin
               if (waitCnt == 16'h0000) begin
                  {ddr.csN, ddr.rasN, ddr.casN, ddr.weN} <= `DIMR_CMD_REF;
                  waitCnt <= `DIMR_GAP;
                  state   <= (state == dimr_pkg::S_REF1) ?
                             dimr_pkg::S_REF2 : dimr_pkg::S_MRS2;
               end
            end
            dimr_pkg::S_MRS2: begin
               if (waitCnt == 16'h0000) begin
                  {ddr.csN, ddr.rasN, ddr.casN, ddr.weN} <= `DIMR_CMD_LOAD;
                  ddr.ba   <= `DIMR_BA_MODE;
                  ddr.addr <= mode;
                  ddr.addr[`DIMR_A8_BIT] <= 1'b0;
                  waitCnt  <= `DIMR_LOAD_BUSY;
                  state    <= dimr_pkg::S_READY;
               end
            end
            dimr_pkg::S_READY: begin
               if (takeWr || takeRd) begin
                  {ddr.csN, ddr.rasN, ddr.casN, ddr.weN} <=
                     takeWr ? `DIMR_CMD_WR : `DIMR_CMD_RD;
                  ddr.ba   <= bank;
                  ddr.addr <= {3'h0, col};
                  beat     <= '0;
                  rdValid  <= takeWr ? rdValid : 1'b0;
                  state    <= takeWr ? dimr_pkg::S_WRITE : dimr_pkg::S_READ;
               end
            end
            dimr_pkg::S_WRITE: begin
               ddr.dqCtl    <= wdata + {12'h000, beat};
               ddr.dm       <= mask;
               ddr.dqCtlOe  <= 1'b1;
               ddr.dqsCtl   <= {2{~beat[0]}};
               ddr.dqsCtlOe <= 1'b1;
               beat         <= beat + 4'h1;
               if (beat == bl - 4'h1) begin
                  waitCnt <= `DIMR_GAP;
                  state   <= dimr_pkg::S_READY;
               end
            end
            dimr_pkg::S_READ: begin
               // Waits on the device's own drive, no fixed latency
               if (ddr.dqDevOe) begin
                  beat <= beat + 4'h1;
                  if (beat == 4'h0) begin
                     rdata   <= ddr.dq;
                     rdValid <= 1'b1;
                  end
                  if (beat == bl - 4'h1) begin
                     waitCnt <= `DIMR_GAP;
                     state   <= dimr_pkg::S_READY;
                  end
               end
            end
            default: state <= dimr_pkg::S_OFF;
         endcase
      end
   end
endmodule

// *** dv/dimr_link_checker.sv ***
/*
 Link checker of the DDR init pair: command order and timing.
 Assumes it sits beside the dimr_if instance, on one clock.
*/
`timescale 1ns/100ps
`include "dimr_defines.svh"
module dimr_link_checker (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // Link
   input  wire logic        cke,
   input  wire logic        csN,
   input  wire logic        rasN,
   input  wire logic        casN,
   input  wire logic        weN,
   input  wire logic [1:0]  ba,
   input  wire logic [12:0] addr,
   input  wire logic        dqCtlOe,
   input  wire logic        dqDevOe
);
   logic [3:0] cmd;
   logic       isLoad;
   logic [7:0] lockCnt;
   logic [1:0] refCnt;
   logic [2:0] clCode;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Command word on the pins
   assign cmd    = {csN, rasN, casN, weN};
   assign isLoad = cmd == `DIMR_CMD_LOAD;
   // Cycles since DLL enable or reset; saturates, never wraps
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         lockCnt <= 8'hFF;
      end else if (isLoad && (ba[0] || addr[`DIMR_A8_BIT])) begin
         lockCnt <= 8'h01;
      end else if (lockCnt != 8'hFF) begin
         lockCnt <= lockCnt + 8'h01;
      end
   end
   // Refreshes since the DLL-resetting load
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         refCnt <= 2'h0;
      end else if (isLoad && !ba[0] && addr[`DIMR_A8_BIT]) begin
         refCnt <= 2'h0;
      end else if (cmd == `DIMR_CMD_REF && refCnt != 2'h3) begin
         refCnt <= refCnt + 2'h1;
      end
   end
   // Latency code of the last mode load
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         clCode <= 3'h6;
      end else if (isLoad && !ba[0]) begin
         clCode <= addr[`DIMR_CL_MSB:`DIMR_CL_LSB];
      end
   end
   cke_quiet_a: assert property (!cke |-> !dqDevOe)
      else $error("device drives data with clock gate low");
   cke_first_a: assert property ($rose(cke) |-> (cmd == `DIMR_CMD_NOP) [*2])
      else $error("command too soon after clock gate rise");
   load_gate_a: assert property (isLoad |-> cke && $past(cke))
      else $error("mode load without clock gate high before");
   load_gap_a: assert property (isLoad |=> (cmd == `DIMR_CMD_NOP) [*2])
      else $error("command inside mode load cycles");
   load_bank_a: assert property (isLoad |-> !ba[1])
      else $error("mode load with bank bit1 high");
   dll_enable_a: assert property (isLoad && ba[0] |-> !addr[`DIMR_EDLL_BIT])
      else $error("extended load leaves DLL disabled");
   lock_wait_a: assert property (!csN && cmd != `DIMR_CMD_NOP |-> lockCnt >= 8'hC8)
      else $error("command during DLL lock wait");
   refresh_pair_a: assert property (isLoad && !ba[0] && !addr[`DIMR_A8_BIT] |-> refCnt >= 2'h2)
      else $error("final mode load before two refreshes");
   read_lat2_a: assert property (cmd == `DIMR_CMD_RD && clCode == `DIMR_CL2 |->
      ##1 !dqDevOe ##1 dqDevOe)
      else $error("read data not at latency two");
   read_lat3_a: assert property (cmd == `DIMR_CMD_RD && clCode != `DIMR_CL2 |->
      ##2 !dqDevOe ##1 dqDevOe)
      else $error("read data not at latency three");
   write_beat_a: assert property (cmd == `DIMR_CMD_WR |=> dqCtlOe [*2])
      else $error("write beats not driven after write");
endmodule

// *** dv/tb_top.sv ***
/*
 Bench of the DDR init pair: APB stimulus, init, bursts and masks.
 Assumes src/ on the include path and one 125 MHz clock.
*/
`timescale 1ns/100ps
`include "dimr_defines.svh"
module tb_top;
   logic        clk;
   logic        rst_b;
   logic [7:0]  paddr;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        halfDrive;
   logic        dllOn;
   logic        selfRef;
   logic [31:0] rd;
   logic        se;
   int          err_count;
   int          n_tests;
   dimr_if ddr ();
   // Short power wait keeps each init a few hundred cycles
   dimr_ctrl #(.POWER_CYCLES(20)) dimr_ctrl_i (.clk(clk), .rst_b(rst_b), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .ddr(ddr.ctrl));
   dimr_dev dimr_dev_i (.clk(clk), .rst_b(rst_b), .ddr(ddr.dev), .halfDrive(halfDrive),
      .dllOn(dllOn), .selfRef(selfRef));
   dimr_link_checker dimr_link_checker_i (.clk(clk), .rst_b(rst_b), .cke(ddr.cke),
      .csN(ddr.csN), .rasN(ddr.rasN), .casN(ddr.casN), .weN(ddr.weN), .ba(ddr.ba),
      .addr(ddr.addr), .dqCtlOe(ddr.dqCtlOe), .dqDevOe(ddr.dqDevOe));
   // Clock at 8 ns
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic end_sim();
      $display("comparisons %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One APB transfer; result left in rd and se
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (i = 0; i < 20 && pready !== 1'b1; i++) begin
         @(posedge clk);
      end
      if (i == 20) begin
         err_count++;
         end_sim();
      end
      rd = prdata;
      se = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   // Poll until idle and ready; bounded
   task automatic waitRdy();
      int i;
      for (i = 0; i < 400; i++) begin
         apb(1'b0, `DIMR_REG_STATUS, 32'h0);
         if (rd[1] === 1'b1 && rd[2] === 1'b0) begin
            return;
         end
      end
      err_count++;
      end_sim();
   endtask
   // One burst, then first read beat fetched into rd
   task automatic burst(input logic rdOp, input logic [31:0] adr, input logic [15:0] d);
      apb(1'b1, `DIMR_REG_ADDR, adr);
      apb(1'b1, `DIMR_REG_WDATA, {16'h0000, d});
      apb(1'b1, `DIMR_REG_CTRL, rdOp ? 32'h4 : 32'h2);
      waitRdy();
      apb(1'b0, `DIMR_REG_RDATA, 32'h0);
   endtask
   // Unmapped write refused, mode reset value, pins quiet
   task automatic t_reset();
      apb(1'b1, 8'h1C, 32'h0000_1FFF);
      chk({31'h0, se}, 32'h1);
      apb(1'b0, `DIMR_REG_MODE, 32'h0);
      chk(rd, {19'h0, `DIMR_MODE_RST});
      chk({30'h0, ddr.cke, ddr.dqDevOe}, 32'h0);
   endtask
   // Each burst length, type and latency: init, write at 3, read block base
   task automatic t_modes();
      logic [12:0] md [4];
      logic [3:0]  bl;
      logic [2:0]  t;
      logic [15:0] dat;
      int          k;
      md = '{13'h0021, 13'h003A, 13'h0063, 13'h002B};
      for (k = 0; k < 4; k++) begin
         // Init runs only from power-off, so each mode gets a fresh reset
         if (k > 0) begin
            rst_b <= 1'b0;
            repeat (4) @(posedge clk);
            rst_b <= 1'b1;
         end
         dat = 16'h1000 * 16'(k + 1);
         apb(1'b1, `DIMR_REG_EMODE, k[0] ? 32'h2 : 32'h0);
         apb(1'b1, `DIMR_REG_MODE, {19'h0, md[k]});
         apb(1'b1, `DIMR_REG_CTRL, 32'h1);
         waitRdy();
         chk({31'h0, halfDrive}, {31'h0, k[0]});
         chk({31'h0, dllOn}, 32'h1);
         chk({31'h0, selfRef}, 32'h0);
         apb(1'b0, `DIMR_REG_MODE, 32'h0);
         chk(rd, {19'h0, md[k]});
         bl = 4'h1 << md[k][1:0];
         t  = 3'h3 & ~3'(bl - 4'h1);
         burst(1'b0, 32'h3, dat);
         burst(1'b1, {29'h0, t}, 16'h0);
         chk(rd, {16'h0, dat + 16'((md[k][3] ? (t ^ 3'h3) : (t - 3'h3)) & 3'(bl - 4'h1))});
      end
   endtask
   // Byte masks: lower then upper masked; read with mask set
   task automatic t_mask();
      logic [15:0] old;
      logic [15:0] nw;
      logic [15:0] exp;
      logic [1:0]  m;
      old = 16'h1234;
      burst(1'b0, 32'h8, old);
      for (m = 2'h1; m != 2'h3; m++) begin
         nw  = m[0] ? 16'hABCD : 16'h5678;
         exp = {m[1] ? old[15:8] : nw[15:8], m[0] ? old[7:0] : nw[7:0]};
         burst(1'b0, {14'h0, m, 16'h0008}, nw);
         burst(1'b1, {14'h0, m, 16'h0008}, 16'h0);
         chk(rd, {16'h0, exp});
         old = exp;
      end
   endtask
   // Reset for four cycles, then scenarios
   initial begin
      rst_b     = 1'b0;
      psel      = 1'b0;
      penable   = 1'b0;
      pwrite    = 1'b0;
      paddr     = 8'h00;
      pwdata    = 32'h0;
      err_count = 0;
      n_tests   = 0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      t_reset();
      t_modes();
      t_mask();
      end_sim();
   end
endmodule
